// file: adsp_pkg.sv
/*
 * Shared constants for the converter serial port: word layout, frame lengths
 * and the clock divider that makes the ADC master clock enable.
 * Assumes a single 100 MHz system clock.
 */
package adsp_pkg;
    localparam int WORD_BITS = 16;
    localparam int LEAD_BITS = 4;
    localparam int CODE_BITS = 12;
    localparam int CONV_EDGES = 19;
    localparam int CLK_HZ = 100_000_000;
    localparam int ADC_CLK_HZ = 2_000_000;
    localparam int HALF_DIV = CLK_HZ / (2 * ADC_CLK_HZ);
    localparam logic [3:0] LEAD_ZERO = 4'h0;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h10;
    localparam logic [4:0] CNT_CONV = 5'h13;
    localparam logic [11:0] CODE_RESET = 12'h000;
endpackage

// file: adsp_shift.sv
/*
 * Serial input latch of the DAC: shifts one bit per capture strobe and
 * presents the last W bits from a register.
 * Assumes the caller strobes only inside a frame.
 */
`timescale 1ns/1ps
`default_nettype none
module adsp_shift #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Shift control
    input wire logic shift_en,
    input wire logic bit_in,
    // Captured word
    output logic [W-1:0] word_r
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_r <= '0;
        end else if (shift_en) begin
            word_r <= {word_r[W-2:0], bit_in};
        end
    end
endmodule
`default_nettype wire

// file: adsp_port.sv
/*
 * Digital control and serial port of a combined 12-bit ADC and DAC.
 * Assumes all pin inputs are synchronous to CLK and open-drain lines are pulled up externally.
 */
// Function
// - Convert-start rising edge starts conversion, holds
// - ADC word: four zeros, 12 bits MSB-first
// - Data changes on rising receive clock edge
// - Frame low at start; bit valid first fall
// - ADC serial outputs are open-drain only
// - Receive clock derived from ADC master clock
// - Gated mode: clock released after conversion
// - Mode input selects gated or continuous clock
// - Input latch and output latch; output drives
// - Transmit bits captured on falling clock edges
// - Sixteen falling edges captured after frame falls
// - First four bits ignored; twelve form code
// - Load strobe fall copies input to output
// - Load held low: update at sixteenth edge
// - Load fall mid-word defers update
// - Load released mid-word cancels update
// - Codes are two's complement, FS/4096 step
// - Gated conversion lasts nineteen clock rises
`timescale 1ns/1ps
`default_nettype none
module adsp_port #(
    parameter int HALF = adsp_pkg::HALF_DIV
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Mode and conversion
    input wire logic CLOCK_CONTINUOUS,
    input wire logic CONVERT_START_N,
    input wire logic [adsp_pkg::CODE_BITS-1:0] ADC_RESULT,
    output logic TRACK_HOLD,
    output logic CONVERTING,
    // Receive serial, open-drain
    input wire logic RX_CLOCK_I,
    output logic RX_CLOCK_O,
    output logic RX_CLOCK_OE,
    input wire logic RX_FRAME_N_I,
    output logic RX_FRAME_N_O,
    output logic RX_FRAME_N_OE,
    input wire logic RX_SERIAL_OUT_I,
    output logic RX_SERIAL_OUT_O,
    output logic RX_SERIAL_OUT_OE,
    // Transmit serial
    input wire logic TX_SERIAL_CLOCK,
    input wire logic TX_FRAME_N,
    input wire logic TX_SERIAL_IN,
    input wire logic DAC_LOAD_N,
    // DAC output latch
    output logic [adsp_pkg::CODE_BITS-1:0] DAC_CODE
);
    import adsp_pkg::*;

    typedef enum logic [1:0] {ADSP_IDLE = 2'b00, ADSP_CONV = 2'b01} adsp_state_t;

    // ------------------------------------------------------------------
    // ADC master clock divider
    // ------------------------------------------------------------------
    logic [7:0] div_r;
    logic mclk_r;
    logic rise_en;
    logic fall_en;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            div_r <= 8'h00;
            mclk_r <= 1'b0;
        end else if (div_r == 8'(HALF - 1)) begin
            div_r <= 8'h00;
            mclk_r <= ~mclk_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    assign rise_en = (div_r == 8'(HALF - 1)) && !mclk_r;
    assign fall_en = (div_r == 8'(HALF - 1)) && mclk_r;

    // ------------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------------
    adsp_state_t state_r;
    logic cs_d_r;
    logic start;
    logic [4:0] conv_cnt_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] out_sr_r;
    logic frame_r;
    logic data_r;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cs_d_r <= 1'b1;
        end else begin
            cs_d_r <= CONVERT_START_N;
        end
    end
    assign start = CONVERT_START_N && !cs_d_r && state_r == ADSP_IDLE;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= ADSP_IDLE;
            conv_cnt_r <= CNT_ZERO;
        end else begin
            unique case (state_r)
                ADSP_IDLE: begin
                    if (start) begin
                        state_r <= ADSP_CONV;
                        conv_cnt_r <= CNT_ZERO;
                    end
                end
                ADSP_CONV: begin
                    if (rise_en) begin
                        if (conv_cnt_r == CNT_CONV - 5'h01) begin
                            state_r <= ADSP_IDLE;
                        end
                        conv_cnt_r <= conv_cnt_r + 5'h01;
                    end
                end
                default: begin
                    state_r <= ADSP_IDLE;
                end
            endcase
        end
    end
    assign CONVERTING = (state_r == ADSP_CONV);
    assign TRACK_HOLD = CONVERTING;

    // ------------------------------------------------------------------
    // Receive clock fall detection
    // ------------------------------------------------------------------
    // The host takes a bit on every fall of the receive clock pin, and switching the gated
    // clock on while the master clock is low makes such a fall too. The word only advances
    // on a rise that follows a pin fall inside the frame, so the first leading zero is the
    // bit that stands at the first fall whatever the master clock phase at start.
    logic rck_oe_d_r;
    logic rck_fell;
    logic fall_seen_r;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rck_oe_d_r <= 1'b0;
        end else begin
            rck_oe_d_r <= RX_CLOCK_OE;
        end
    end
    assign rck_fell = RX_CLOCK_OE && !rck_oe_d_r;

    // ------------------------------------------------------------------
    // ADC serial word out
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            out_sr_r <= 16'h0000;
            bit_cnt_r <= CNT_ZERO;
            fall_seen_r <= 1'b0;
            frame_r <= 1'b1;
            data_r <= 1'b1;
        end else if (start) begin
            out_sr_r <= {LEAD_ZERO[LEAD_BITS-2:0], ADC_RESULT, 1'b0};
            bit_cnt_r <= CNT_ZERO;
            fall_seen_r <= 1'b0;
            frame_r <= 1'b0;
            data_r <= LEAD_ZERO[LEAD_BITS-1];
        end else if (!frame_r) begin
            if (rck_fell) begin
                fall_seen_r <= 1'b1;
            end
            if (rise_en && (fall_seen_r || rck_fell)) begin
                if (bit_cnt_r == CNT_LAST - 5'h01) begin
                    frame_r <= 1'b1;
                    data_r <= 1'b1;
                end else begin
                    data_r <= out_sr_r[WORD_BITS-1];
                    out_sr_r <= {out_sr_r[WORD_BITS-2:0], 1'b0};
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
            end
        end
    end

    // Open-drain: only ever drive low, release otherwise.
    assign RX_FRAME_N_O = 1'b0;
    assign RX_FRAME_N_OE = !frame_r;
    assign RX_SERIAL_OUT_O = 1'b0;
    assign RX_SERIAL_OUT_OE = !frame_r && !data_r;
    assign RX_CLOCK_O = 1'b0;
    assign RX_CLOCK_OE = !mclk_r && (CLOCK_CONTINUOUS || CONVERTING);

    // ------------------------------------------------------------------
    // DAC serial input and load
    // ------------------------------------------------------------------
    logic tx_serial_clock_d_r;
    logic tfs_d_r;
    logic ld_d_r;
    logic tfall;
    logic in_word_r;
    logic [4:0] rx_cnt_r;
    logic cap;
    logic last;
    logic [15:0] in_latch;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tx_serial_clock_d_r <= 1'b1;
            tfs_d_r <= 1'b1;
            ld_d_r <= 1'b1;
        end else begin
            tx_serial_clock_d_r <= TX_SERIAL_CLOCK;
            tfs_d_r <= TX_FRAME_N;
            ld_d_r <= DAC_LOAD_N;
        end
    end
    assign tfall = tx_serial_clock_d_r && !TX_SERIAL_CLOCK;
    assign cap = tfall && in_word_r;
    assign last = cap && rx_cnt_r == CNT_LAST - 5'h01;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            in_word_r <= 1'b0;
            rx_cnt_r <= CNT_ZERO;
        end else if (tfs_d_r && !TX_FRAME_N) begin
            in_word_r <= 1'b1;
            rx_cnt_r <= CNT_ZERO;
        end else if (cap) begin
            rx_cnt_r <= rx_cnt_r + 5'h01;
            if (last) begin
                in_word_r <= 1'b0;
            end
        end
    end

    adsp_shift #(
        .W(WORD_BITS)
    ) adsp_shift_i (
        .clk(CLK),
        .rst_n(RST_N),
        .shift_en(cap),
        .bit_in(TX_SERIAL_IN),
        .word_r(in_latch)
    );

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            DAC_CODE <= CODE_RESET;
        end else if (last && !DAC_LOAD_N) begin
            DAC_CODE <= {in_latch[CODE_BITS-2:0], TX_SERIAL_IN};
        end else if (ld_d_r && !DAC_LOAD_N && !in_word_r) begin
            DAC_CODE <= in_latch[CODE_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_frame_at_start: assert property (@(posedge CLK) disable iff (!RST_N)
        start |=> RX_FRAME_N_OE)
        else $error("frame not low after start");
    a_first_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        start |=> RX_SERIAL_OUT_OE)
        else $error("first leading zero not driven at start");
    a_word_loaded: assert property (@(posedge CLK) disable iff (!RST_N)
        start |=> {data_r, out_sr_r[WORD_BITS-1:1]} == {LEAD_ZERO, $past(ADC_RESULT)})
        else $error("output word not loaded at start");
    a_conv_ends_gated: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(CONVERTING) |-> conv_cnt_r == CNT_CONV)
        else $error("conversion length wrong");
    a_clock_released: assert property (@(posedge CLK) disable iff (!RST_N)
        (!CLOCK_CONTINUOUS && !CONVERTING) |-> !RX_CLOCK_OE)
        else $error("clock driven when idle");
    a_gated_release: assert property (@(posedge CLK) disable iff (!RST_N)
        (!CLOCK_CONTINUOUS && CONVERTING && rise_en && conv_cnt_r == CNT_CONV - 5'h01)
        |=> (!CONVERTING && !RX_CLOCK_OE))
        else $error("gated clock not released at conversion end");
    a_od_low_only: assert property (@(posedge CLK) disable iff (!RST_N)
        !RX_SERIAL_OUT_O && !RX_FRAME_N_O && !RX_CLOCK_O)
        else $error("open-drain drove high");
    a_lead_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (rise_en && !frame_r && (fall_seen_r || rck_fell) && bit_cnt_r < 5'(LEAD_BITS - 1)) |=> !data_r)
        else $error("leading bit not zero");
    a_data_on_rise: assert property (@(posedge CLK) disable iff (!RST_N)
        (!start && !rise_en) |=> $stable(data_r))
        else $error("data changed away from a clock rise");
    a_frame_held: assert property (@(posedge CLK) disable iff (!RST_N)
        (!frame_r && !rise_en) |=> !frame_r)
        else $error("frame released away from a clock rise");
    a_frame_release: assert property (@(posedge CLK) disable iff (!RST_N)
        (rise_en && !frame_r && !start && (fall_seen_r || rck_fell) && bit_cnt_r == CNT_LAST - 5'h01) |=> frame_r)
        else $error("frame not released");
    a_hold_on_start: assert property (@(posedge CLK) disable iff (!RST_N)
        start |=> TRACK_HOLD)
        else $error("no hold at start");
    a_cap_in_word: assert property (@(posedge CLK) disable iff (!RST_N)
        cap |-> rx_cnt_r < CNT_LAST)
        else $error("capture beyond sixteen bits");
    a_no_update_midword: assert property (@(posedge CLK) disable iff (!RST_N)
        (in_word_r && !last) |=> $stable(DAC_CODE))
        else $error("output changed mid word");
    a_load_at_last: assert property (@(posedge CLK) disable iff (!RST_N)
        (last && !DAC_LOAD_N) |=> DAC_CODE == {$past(in_latch[CODE_BITS-2:0]), $past(TX_SERIAL_IN)})
        else $error("sixteenth edge load wrong");
    a_load_cancel: assert property (@(posedge CLK) disable iff (!RST_N)
        (last && DAC_LOAD_N) |=> $stable(DAC_CODE))
        else $error("output changed with load released");
    a_load_on_fall: assert property (@(posedge CLK) disable iff (!RST_N)
        (ld_d_r && !DAC_LOAD_N && !in_word_r) |=> DAC_CODE == $past(in_latch[CODE_BITS-1:0]))
        else $error("load strobe fall did not copy the input latch");
endmodule
`default_nettype wire

// file: adsp_host_rx.sv
/*
 * Host receive port model: collects the serial word from the pulled-up
 * receive lines and counts receive clock rises.
 * Assumes the bench resolves each open-drain line to its wire level.
 */
`timescale 1ns/1ps
`default_nettype none
module adsp_host_rx (
    // Clock and clear
    input wire logic clk,
    input wire logic clr,
    // Receive wire levels
    input wire logic rck,
    input wire logic rfs_n,
    input wire logic rdat,
    // Collected word and counts
    output logic [15:0] word_r,
    output logic [7:0] bits_r,
    output logic [7:0] rises_r
);
    logic rck_r = 1'b1;
    always_ff @(posedge clk) begin
        rck_r <= rck;
        if (clr) begin
            word_r <= 16'h0000;
            bits_r <= 8'h00;
            rises_r <= 8'h00;
        end else begin
            if (!rck_r && rck) begin
                rises_r <= rises_r + 8'h01;
            end
            if (rck_r && !rck && !rfs_n) begin
                word_r <= {word_r[14:0], rdat};
                bits_r <= bits_r + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: adc_dac_serial_port_tb.sv
/*
 * Self-checking bench for the converter serial port.
 * Assumes the port is built with a short master clock divider.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_dac_serial_port_tb;
    import adsp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode = 1'b0;
    logic conv_n = 1'b1;
    logic [11:0] result = 12'h000;
    logic tck = 1'b1;
    logic tfs_n = 1'b1;
    logic tdat = 1'b0;
    logic dac_load_n_n = 1'b1;
    logic clr = 1'b1;
    logic track_hold, conv, ck_o, ck_oe, fs_o, fs_oe, d_o, d_oe;
    logic [11:0] dac;
    logic [15:0] word;
    logic [7:0] bits, rises;
    int n_errors = 0;
    int samples_checked = 0;
    wire rck = ck_oe ? ck_o : 1'b1;
    wire rfs_n = fs_oe ? fs_o : 1'b1;
    wire rdat = d_oe ? d_o : 1'b1;
    always #5 clk = ~clk;
    adsp_port #(.HALF(2)) adsp_port_i (.CLK(clk), .RST_N(rst_n), .CLOCK_CONTINUOUS(mode),
        .CONVERT_START_N(conv_n), .ADC_RESULT(result), .TRACK_HOLD(track_hold), .CONVERTING(conv),
        .RX_CLOCK_I(rck), .RX_CLOCK_O(ck_o), .RX_CLOCK_OE(ck_oe), .RX_FRAME_N_I(rfs_n),
        .RX_FRAME_N_O(fs_o), .RX_FRAME_N_OE(fs_oe), .RX_SERIAL_OUT_I(rdat), .RX_SERIAL_OUT_O(d_o),
        .RX_SERIAL_OUT_OE(d_oe), .TX_SERIAL_CLOCK(tck), .TX_FRAME_N(tfs_n), .TX_SERIAL_IN(tdat),
        .DAC_LOAD_N(dac_load_n_n), .DAC_CODE(dac));
    adsp_host_rx adsp_host_rx_i (.clk(clk), .clr(clr), .rck(rck), .rfs_n(rfs_n), .rdat(rdat),
        .word_r(word), .bits_r(bits), .rises_r(rises));
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic convert(input logic cont, input logic [11:0] res);
        int k;
        mode = cont;
        result = res;
        cyc(4);
        clr = 1'b0;
        conv_n = 1'b0;
        cyc(2);
        conv_n = 1'b1;
        cyc(2);
        chk("track hold", 16'h0001, 16'(track_hold));
        chk("frame low", 16'h0000, 16'(rfs_n));
        k = 0;
        while (conv === 1'b1 && k < 400) begin
            cyc(1);
            k++;
        end
        chk("conversion ended", 16'h0000, 16'(conv));
        cyc(10);
        chk("adc word", {LEAD_ZERO, res}, word);
        chk("bits", 16'h0010, 16'(bits));
        chk("frame released", 16'h0001, 16'(rfs_n));
        if (!cont) begin
            chk("clock rises", 16'h0013, 16'(rises));
            chk("clock parked", 16'h0001, 16'(rck));
        end else begin
            chk("clock runs", 16'h0001, 16'(rises > 8'h14));
        end
        clr = 1'b1;
    endtask
    task automatic send(input logic [15:0] w, input int ld_fall, input int ld_rise);
        logic [11:0] old;
        old = dac;
        tfs_n = 1'b0;
        cyc(2);
        for (int i = 0; i < 16; i++) begin
            if (i == ld_fall) dac_load_n_n = 1'b0;
            if (i == ld_rise) dac_load_n_n = 1'b1;
            if (i == ld_fall + 2) chk("no load mid word", {4'h0, old}, {4'h0, dac});
            tdat = w[15-i];
            tck = 1'b1;
            cyc(2);
            tck = 1'b0;
            cyc(2);
        end
        cyc(2);
        tfs_n = 1'b1;
        cyc(2);
    endtask
    task automatic dac_held;
        dac_load_n_n = 1'b0;
        cyc(3);
        send(16'hf9a3, -1, -1);
        chk("dac held", 16'h09a3, {4'h0, dac});
        dac_load_n_n = 1'b1;
        cyc(2);
    endtask
    task automatic dac_strobe;
        send(16'h0456, -1, -1);
        chk("dac waits", 16'h09a3, {4'h0, dac});
        dac_load_n_n = 1'b0;
        cyc(3);
        chk("dac strobe", 16'h0456, {4'h0, dac});
        dac_load_n_n = 1'b1;
        cyc(2);
    endtask
    task automatic dac_late;
        send(16'hebcd, 5, -1);
        chk("dac late", 16'h0bcd, {4'h0, dac});
        dac_load_n_n = 1'b1;
        cyc(2);
    endtask
    task automatic dac_cancel;
        send(16'h0321, 3, 9);
        chk("dac cancel", 16'h0bcd, {4'h0, dac});
    endtask
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    initial begin
        cyc(8);
        rst_n = 1'b1;
        cyc(2);
        chk("dac reset", 16'h0000, {4'h0, dac});
        convert(1'b0, 12'ha5c);
        convert(1'b1, 12'h7ff);
        dac_held();
        dac_strobe();
        dac_late();
        dac_cancel();
        print_verdict();
    end
endmodule
`default_nettype wire
